/* hw/tlsc_top.sv */
// Transceiver low-speed control: flags, transmit off, monitors, APB
`timescale 1ns/1ps
`default_nettype none
module tlsc_top
    import tlsc_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Module pins, asynchronous to pclk
    input wire logic tx_off_pin,
    input wire logic rate_pick_0,
    input wire logic rate_pick_1,
    // Analog fault detectors, asynchronous to pclk
    input wire logic laser_fault_in,
    input wire logic eye_trip_in,
    // Digitised monitor samples, same clock
    input wire tlsc_sample_t sample,
    // Open-drain fault flag pin
    output logic fault_pin_o,
    output logic fault_pin_oe_n,
    // Open-drain signal-lost flag pin
    output logic los_pin_o,
    output logic los_pin_oe_n,
    // Laser driver enable and interrupt
    output logic laser_en,
    output logic irq
);

    // ------------------------------------------------------------
    // Decode helper
    // ------------------------------------------------------------

    // Word inside an 8-word table region holding a valid channel
    function automatic logic tab_hit(input logic [7:0] a,
                                     input logic [7:0] base);
        tab_hit = (a[7:5] == base[7:5]) && (a[4:2] < 3'h5)
                  && (a[1:0] == 2'h0);
    endfunction

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;
    logic tx_off_s;
    logic tx_off_prev_q;
    logic laser_flt_s;
    logic eye_trip_s;
    logic [1:0] rate_s;
    logic [1:0] ctrl_q;
    logic fault_q;
    logic fault_d;
    logic fault_cond;
    logic fault_clr;
    tlsc_los_t los_st_q;
    tlsc_los_t los_st_d;
    logic los_q;
    logic los_d;
    logic laser_en_q;
    logic [IRQ_W-1:0] ists_q;
    logic [IRQ_W-1:0] ists_d;
    logic [IRQ_W-1:0] ien_q;
    logic [IRQ_W-1:0] iev;
    logic [IRQ_W-1:0] iclr;
    logic irq_q;
    logic alarm_any;
    logic warn_any;
    logic alarm_prev_q;
    logic warn_prev_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic od_low_q;
    logic [NCH-1:0][15:0] mon_val;
    tlsc_flags_t mon_flags;
    logic setup;
    logic wr;
    logic [2:0] ch;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_ists;
    logic hit_iclr;
    logic hit_ien;
    logic hit_mon;
    logic hit_ahi;
    logic hit_alo;
    logic hit_whi;
    logic hit_wlo;
    logic hit_cal;
    logic mapped;
    logic [31:0] rd_d;
    logic [31:0] stat_word;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------

    // Off bit resets high: a floating input behaves as pulled up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= SYNC_RST;
            sync2_q <= SYNC_RST;
        end else if (ce) begin
            sync1_q <= {eye_trip_in, laser_fault_in, rate_pick_1,
                        rate_pick_0, tx_off_pin};
            sync2_q <= sync1_q;
        end
    end

    // Only the second stage is read past this point
    assign tx_off_s = sync2_q[0];
    assign rate_s = sync2_q[2:1];
    assign laser_flt_s = sync2_q[3];
    assign eye_trip_s = sync2_q[4];

    // ------------------------------------------------------------
    // Monitor capture
    // ------------------------------------------------------------
    tlsc_mon u_mon (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .sample(sample),
        .value(mon_val),
        .flags(mon_flags)
    );

    assign alarm_any = |{mon_flags.ahi, mon_flags.alo};
    assign warn_any = |{mon_flags.whi, mon_flags.wlo};

    // ------------------------------------------------------------
    // Transmit fault
    // ------------------------------------------------------------

    // Laser trouble: detector pins or bias / output power over limit
    assign fault_cond = laser_flt_s | eye_trip_s
                        | mon_flags.ahi[CH_BIAS]
                        | mon_flags.ahi[CH_TXP];

    // Cleared by a rising off input or a software pulse
    assign fault_clr = (tx_off_s & ~tx_off_prev_q)
                       | (wr && hit_ctrl && pwdata[CTRL_FLT_CLR]);

    // Latched; a live condition wins over any clear
    assign fault_d = fault_cond | (fault_q & ~fault_clr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_q <= 1'b0;
            tx_off_prev_q <= 1'b1;
        end else if (ce) begin
            fault_q <= fault_d;
            tx_off_prev_q <= tx_off_s;
        end
    end

    // ------------------------------------------------------------
    // Receive signal lost, with hysteresis
    // ------------------------------------------------------------

    // Hysteresis stops the flag chattering around one threshold.
    // Host must still qualify received data on its own.
    always_comb begin
        los_st_d = los_st_q;
        case (los_st_q)
            LOS_SET: begin
                if (mon_val[CH_RXP] > LOS_OFF_LVL) begin
                    los_st_d = LOS_CLR;
                end
            end
            LOS_CLR: begin
                if (mon_val[CH_RXP] < LOS_ON_LVL) begin
                    los_st_d = LOS_SET;
                end
            end
            default: begin
                los_st_d = LOS_SET;
            end
        endcase
    end

    assign los_d = (los_st_d == LOS_SET);

    // Starts as lost until a real reading says otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            los_st_q <= LOS_SET;
            los_q <= 1'b1;
        end else if (ce) begin
            los_st_q <= los_st_d;
            los_q <= los_d;
        end
    end

    // ------------------------------------------------------------
    // Laser enable
    // ------------------------------------------------------------

    // Rate picks never reach here: only one line rate exists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            laser_en_q <= 1'b0;
        end else if (ce) begin
            laser_en_q <= ~tx_off_s & ~ctrl_q[CTRL_SOFT_OFF];
        end
    end

    // ------------------------------------------------------------
    // Open-drain pins
    // ------------------------------------------------------------

    // Pin data is always low; a flag high means release the pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            od_low_q <= 1'b0;
        end else if (ce) begin
            od_low_q <= 1'b0;
        end
    end

    assign fault_pin_o = od_low_q;
    assign fault_pin_oe_n = fault_q;
    assign los_pin_o = od_low_q;
    assign los_pin_oe_n = los_q;
    assign laser_en = laser_en_q;

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------

    // Rising edges of each event
    assign iev[IRQ_FAULT] = fault_d & ~fault_q;
    assign iev[IRQ_LOS_ON] = los_d & ~los_q;
    assign iev[IRQ_LOS_OFF] = ~los_d & los_q;
    assign iev[IRQ_ALARM] = alarm_any & ~alarm_prev_q;
    assign iev[IRQ_WARN] = warn_any & ~warn_prev_q;

    // Clear by writing ones; an event in the same cycle wins
    assign iclr = (wr && hit_iclr) ? pwdata[IRQ_W-1:0] : '0;
    assign ists_d = iev | (ists_q & ~iclr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ists_q <= '0;
            alarm_prev_q <= 1'b0;
            warn_prev_q <= 1'b0;
            irq_q <= 1'b0;
        end else if (ce) begin
            ists_q <= ists_d;
            alarm_prev_q <= alarm_any;
            warn_prev_q <= warn_any;
            irq_q <= |(ists_d & ien_q);
        end
    end

    assign irq = irq_q;

    // ------------------------------------------------------------
    // APB address decode
    // ------------------------------------------------------------
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & pready_q;
    assign ch = paddr[4:2];
    assign hit_ctrl = (paddr == OFS_CTRL);
    assign hit_stat = (paddr == OFS_STAT);
    assign hit_ists = (paddr == OFS_ISTS);
    assign hit_iclr = (paddr == OFS_ICLR);
    assign hit_ien = (paddr == OFS_IEN);
    assign hit_mon = tab_hit(paddr, OFS_MON);
    assign hit_ahi = tab_hit(paddr, OFS_AHI);
    assign hit_alo = tab_hit(paddr, OFS_ALO);
    assign hit_whi = tab_hit(paddr, OFS_WHI);
    assign hit_wlo = tab_hit(paddr, OFS_WLO);
    assign hit_cal = tab_hit(paddr, OFS_CAL);
    assign mapped = hit_ctrl | hit_stat | hit_ists | hit_iclr
                    | hit_ien | hit_mon | hit_ahi | hit_alo
                    | hit_whi | hit_wlo | hit_cal;

    // Live pin and flag view; rate picks shown but unused
    assign stat_word = {26'h0000000, rate_s, los_q, fault_q,
                        laser_en_q, tx_off_s};

    // ------------------------------------------------------------
    // APB read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_d = 32'h00000000;
        if (hit_ctrl) begin
            rd_d = {30'h00000000, ctrl_q};
        end else if (hit_stat) begin
            rd_d = stat_word;
        end else if (hit_ists) begin
            rd_d = {27'h0000000, ists_q};
        end else if (hit_ien) begin
            rd_d = {27'h0000000, ien_q};
        end else if (hit_mon) begin
            rd_d = {16'h0000, mon_val[ch]};
        end else if (hit_ahi) begin
            rd_d = {16'h0000, TAB_AHI[ch]};
        end else if (hit_alo) begin
            rd_d = {16'h0000, TAB_ALO[ch]};
        end else if (hit_whi) begin
            rd_d = {16'h0000, TAB_WHI[ch]};
        end else if (hit_wlo) begin
            rd_d = {16'h0000, TAB_WLO[ch]};
        end else if (hit_cal) begin
            rd_d = {16'h0000, TAB_CAL[ch]};
        end
    end

    // ------------------------------------------------------------
    // APB response and writable registers
    // ------------------------------------------------------------

    // Answer is ready in the first access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else if (ce) begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup && !pwrite) begin
                prdata_q <= rd_d;
            end
        end
    end

    // Clear bit is a pulse and is never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            ien_q <= IEN_RST;
        end else if (ce && wr) begin
            if (hit_ctrl) begin
                ctrl_q <= {1'b0, pwdata[CTRL_SOFT_OFF]};
            end
            if (hit_ien) begin
                ien_q <= pwdata[IRQ_W-1:0];
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

endmodule // tlsc_top
`default_nettype wire

/* hw/tlsc_pkg.sv */
// Package: constants and types for the transceiver low-speed control block
package tlsc_pkg;

    // ------------------------------------------------------------
    // Monitor channels
    // ------------------------------------------------------------
    localparam int NCH = 5;
    localparam logic [2:0] CH_TEMP = 3'h0;
    localparam logic [2:0] CH_VCC = 3'h1;
    localparam logic [2:0] CH_BIAS = 3'h2;
    localparam logic [2:0] CH_TXP = 3'h3;
    localparam logic [2:0] CH_RXP = 3'h4;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_ISTS = 8'h08;
    localparam logic [7:0] OFS_ICLR = 8'h0C;
    localparam logic [7:0] OFS_IEN = 8'h10;
    localparam logic [7:0] OFS_MON = 8'h20;
    localparam logic [7:0] OFS_AHI = 8'h40;
    localparam logic [7:0] OFS_ALO = 8'h60;
    localparam logic [7:0] OFS_WHI = 8'h80;
    localparam logic [7:0] OFS_WLO = 8'hA0;
    localparam logic [7:0] OFS_CAL = 8'hC0;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_SOFT_OFF = 0;
    localparam int CTRL_FLT_CLR = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam int IRQ_W = 5;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_LOS_ON = 1;
    localparam int IRQ_LOS_OFF = 2;
    localparam int IRQ_ALARM = 3;
    localparam int IRQ_WARN = 4;
    localparam logic [IRQ_W-1:0] IEN_RST = 5'h00;
    // Pin synchroniser order: off, pick0, pick1, laser fault, eye trip
    localparam int NSYNC = 5;
    localparam logic [NSYNC-1:0] SYNC_RST = 5'h01;

    // ------------------------------------------------------------
    // Factory tables, fixed at build time
    // ------------------------------------------------------------
    localparam logic [15:0] TAB_AHI [NCH] =
        '{16'h5000, 16'h9000, 16'hC000, 16'hC000, 16'hC000};
    localparam logic [15:0] TAB_ALO [NCH] =
        '{16'h0100, 16'h6000, 16'h0200, 16'h0200, 16'h0080};
    localparam logic [15:0] TAB_WHI [NCH] =
        '{16'h4800, 16'h8800, 16'hA000, 16'hA000, 16'hA000};
    localparam logic [15:0] TAB_WLO [NCH] =
        '{16'h0200, 16'h6800, 16'h0400, 16'h0400, 16'h0100};
    localparam logic [15:0] TAB_CAL [NCH] =
        '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

    // Receive level hysteresis thresholds (raw monitor units)
    localparam logic [15:0] LOS_ON_LVL = 16'h0100;
    localparam logic [15:0] LOS_OFF_LVL = 16'h0180;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic [15:0] data;
    } tlsc_sample_t;

    typedef struct packed {
        logic [NCH-1:0] ahi;
        logic [NCH-1:0] alo;
        logic [NCH-1:0] whi;
        logic [NCH-1:0] wlo;
    } tlsc_flags_t;

    typedef enum logic [1:0] {
        LOS_SET = 2'b01,
        LOS_CLR = 2'b10
    } tlsc_los_t;

endpackage

/* hw/tlsc_mon.sv */
// Monitor capture: calibrated readings and threshold flags per channel
`timescale 1ns/1ps
`default_nettype none
module tlsc_mon
    import tlsc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Digitised monitor samples
    input wire tlsc_sample_t sample,
    // Results
    output logic [NCH-1:0][15:0] value,
    output tlsc_flags_t flags
);

    logic [NCH-1:0][15:0] val_q;

    // ------------------------------------------------------------
    // One capture register per channel
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NCH; i++) begin : g_ch
            logic hit;
            logic [15:0] cal_d;
            assign hit = sample.valid && (sample.chan == 3'(i));
            // Offset wraps; tables keep readings well inside range
            assign cal_d = sample.data + TAB_CAL[i];
            // Latest sample held until the next one for this channel
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    val_q[i] <= 16'h0000;
                end else if (ce && hit) begin
                    val_q[i] <= cal_d;
                end
            end
            // Threshold compare against factory limits
            assign flags.ahi[i] = val_q[i] > TAB_AHI[i];
            assign flags.alo[i] = val_q[i] < TAB_ALO[i];
            assign flags.whi[i] = val_q[i] > TAB_WHI[i];
            assign flags.wlo[i] = val_q[i] < TAB_WLO[i];
        end
    endgenerate

    assign value = val_q;

endmodule // tlsc_mon
`default_nettype wire

/* testbench/tlsc_props.sv */
// Port-level assertions for the transceiver low-speed control block
`timescale 1ns/1ps
`default_nettype none
module tlsc_props
    import tlsc_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and samples in
    input wire logic tx_off_pin,
    input wire logic laser_fault_in,
    input wire logic eye_trip_in,
    input wire tlsc_sample_t sample,
    // Pins out
    input wire logic fault_pin_o,
    input wire logic fault_pin_oe_n,
    input wire logic los_pin_o,
    input wire logic los_pin_oe_n,
    input wire logic laser_en
);
    // ------------------------------------------------------------
    // One clock domain, reset kills every attempt
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Open-drain data stays low; only the enable moves
    chk_fault_od: assert property (fault_pin_o == 1'b0)
        else $error("fault pin data not low");
    chk_los_od: assert property (los_pin_o == 1'b0)
        else $error("signal-lost pin data not low");
    // Four samples cover two sync stages plus the output flop
    chk_tx_off: assert property (tx_off_pin [*4] |-> !laser_en)
        else $error("laser on while transmit-off held");
    chk_laser_flt: assert property (
        laser_fault_in [*4] |-> fault_pin_oe_n)
        else $error("laser fault not flagged");
    chk_eye_flt: assert property (
        eye_trip_in [*4] |-> fault_pin_oe_n)
        else $error("eye-safety trip not flagged");
    chk_los_set: assert property (
        sample.valid && sample.chan == CH_RXP && sample.data < LOS_ON_LVL
        |-> ##2 los_pin_oe_n)
        else $error("low receive level not flagged");
    chk_los_clr: assert property (
        sample.valid && sample.chan == CH_RXP && sample.data > LOS_OFF_LVL
        |-> ##2 !los_pin_oe_n)
        else $error("good receive level still flagged");
    chk_apb_answer: assert property (
        psel && !penable |=> pready ##1 !pready)
        else $error("register answer not a single cycle");
    chk_err_qual: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule // tlsc_props

bind tlsc_top tlsc_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .tx_off_pin(tx_off_pin),
    .laser_fault_in(laser_fault_in), .eye_trip_in(eye_trip_in),
    .sample(sample), .fault_pin_o(fault_pin_o),
    .fault_pin_oe_n(fault_pin_oe_n), .los_pin_o(los_pin_o),
    .los_pin_oe_n(los_pin_oe_n), .laser_en(laser_en)
);
`default_nettype wire

/* testbench/tlsc_host.sv */
// Host board model: flag pull-ups and transmit-off pin drive
`timescale 1ns/1ps
`default_nettype none
module tlsc_host (
    // Device flag pins
    input wire logic fault_pin_o,
    input wire logic fault_pin_oe_n,
    input wire logic los_pin_o,
    input wire logic los_pin_oe_n,
    // Host drive of transmit-off
    input wire logic tx_drv_en,
    input wire logic tx_drv,
    // Resolved wire levels
    output logic fault_line,
    output logic los_line,
    output logic tx_off_line,
    output logic scl_line,
    output logic sda_line
);
    // Released flags float up through the board pull-ups
    assign fault_line = fault_pin_oe_n ? 1'b1 : fault_pin_o;
    // Signal-lost is only a hint; host framing still qualifies data
    assign los_line = los_pin_oe_n ? 1'b1 : los_pin_o;
    // Undriven pin rises on the module's own pull-up
    assign tx_off_line = tx_drv_en ? tx_drv : 1'b1;
    // Serial lines idle high on board pull-ups
    assign scl_line = 1'b1;
    assign sda_line = 1'b1;
endmodule // tlsc_host
`default_nettype wire

/* testbench/test_transceiver_low_speed_control.sv */
// Self-checking bench for the transceiver low-speed control block
`timescale 1ns/1ps
`default_nettype none
module test_transceiver_low_speed_control
    import tlsc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn, ce, psel, penable, pwrite, pready, pslverr, err_q;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic rate_pick_0, rate_pick_1, laser_fault_in, eye_trip_in;
    logic fault_pin_o, fault_pin_oe_n, los_pin_o, los_pin_oe_n;
    logic laser_en, irq, tx_drv_en, tx_drv, tx_off_pin, fault_line, los_line;
    tlsc_sample_t sample;
    logic [15:0] mon_val [NCH] =
        '{16'h3000, 16'h7000, 16'h0800, 16'h0800, 16'h0800};
    int err_total = 0;
    int n_tests = 0;

    always #25 pclk = ~pclk;

    tlsc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_off_pin(tx_off_pin), .rate_pick_0(rate_pick_0),
        .rate_pick_1(rate_pick_1), .laser_fault_in(laser_fault_in),
        .eye_trip_in(eye_trip_in), .sample(sample),
        .fault_pin_o(fault_pin_o), .fault_pin_oe_n(fault_pin_oe_n),
        .los_pin_o(los_pin_o), .los_pin_oe_n(los_pin_oe_n),
        .laser_en(laser_en), .irq(irq));
    tlsc_host u_host (.fault_pin_o(fault_pin_o),
        .fault_pin_oe_n(fault_pin_oe_n), .los_pin_o(los_pin_o),
        .los_pin_oe_n(los_pin_oe_n), .tx_drv_en(tx_drv_en), .tx_drv(tx_drv),
        .fault_line(fault_line), .los_line(los_line),
        .tx_off_line(tx_off_pin), .scl_line(), .sda_line());

    // ------------------------------------------------------------
    // Compare, verdict and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bchk(input logic b, input logic e);
        check({31'h0, b}, {31'h0, e});
    endtask

    task automatic end_of_test();
        $display("compares=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            end_of_test();
        end
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd_q & m, e);
    endtask

    task automatic rtab(input logic [7:0] a, input logic [15:0] e);
        rchk(a, 32'hFFFFFFFF, {16'h0000, e});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One valid sample, then time for the flag pipeline to settle
    task automatic feed(input logic [2:0] ch, input logic [15:0] d);
        @(posedge pclk);
        sample <= {1'b1, ch, d};
        @(posedge pclk);
        sample.valid <= 1'b0;
        tick(3);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, tx_drv_en, tx_drv} = 6'h00;
        {rate_pick_0, rate_pick_1, laser_fault_in, eye_trip_in} = 4'h0;
        ce = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        sample = '0;
        tick(5);
        presetn <= 1'b1;
        tick(4);
        bchk(laser_en, 1'b0);
        bchk(fault_line, 1'b0);
        bchk(los_line, 1'b1);
        rchk(OFS_STAT, 32'h3F, 32'h09);
        rchk(OFS_IEN, 32'hFFFFFFFF, 32'h0);
        $display("test reset done");
        // Host takes the pin low, then wiggles rate picks
        @(posedge pclk);
        tx_drv_en <= 1'b1;
        tick(4);
        bchk(laser_en, 1'b1);
        @(posedge pclk);
        {rate_pick_0, rate_pick_1} <= 2'b11;
        tick(4);
        bchk(laser_en, 1'b1);
        rchk(OFS_STAT, 32'h3F, 32'h3A);
        @(posedge pclk);
        {rate_pick_0, rate_pick_1, tx_drv} <= 3'b001;
        tick(4);
        bchk(laser_en, 1'b0);
        @(posedge pclk);
        {ce, tx_drv} <= 2'b00;
        tick(4);
        bchk(laser_en, 1'b0);
        ce <= 1'b1;
        tick(4);
        bchk(laser_en, 1'b1);
        $display("test transmit-off done");
        // Laser fault pin with its interrupt unmasked, then eye-safety trip pin masked
        for (int i = 0; i < 2; i++) begin
            wr_iclr: apb(1'b1, OFS_ICLR, 32'h1F);
            apb(1'b1, OFS_IEN, (i == 0) ? 32'h01 : 32'h00);
            @(posedge pclk);
            laser_fault_in <= (i == 0);
            eye_trip_in <= (i == 1);
            tick(4);
            bchk(fault_line, 1'b1);
            bchk(irq, i == 0);
            rchk(OFS_ISTS, 32'h01, 32'h01);
            @(posedge pclk);
            {laser_fault_in, eye_trip_in} <= 2'b00;
            tick(4);
            bchk(fault_line, 1'b1);
            apb(1'b1, OFS_CTRL, 32'h02);
            tick(2);
            bchk(fault_line, 1'b0);
        end
        apb(1'b1, OFS_ICLR, 32'h1F);
        tick(2);
        bchk(irq, 1'b0);
        $display("test fault done");
        // Live readings, then alarm and signal-lost hysteresis
        for (int c = 0; c < NCH; c++) begin
            feed(3'(c), mon_val[c]);
            rtab(OFS_MON + 8'(4 * c), mon_val[c]);
        end
        bchk(los_line, 1'b0);
        apb(1'b1, OFS_ICLR, 32'h1F);
        feed(CH_TEMP, 16'h6000);
        feed(CH_RXP, 16'h0050);
        bchk(los_line, 1'b1);
        feed(CH_RXP, 16'h0150);
        bchk(los_line, 1'b1);
        rchk(OFS_ISTS, 32'h1E, 32'h1A);
        $display("test monitors done");
        // Factory tables are read-only
        apb(1'b1, OFS_AHI, 32'h1234);
        for (int c = 0; c < NCH; c++) begin
            rtab(OFS_AHI + 8'(4 * c), TAB_AHI[c]);
            rtab(OFS_ALO + 8'(4 * c), TAB_ALO[c]);
            rtab(OFS_WHI + 8'(4 * c), TAB_WHI[c]);
            rtab(OFS_WLO + 8'(4 * c), TAB_WLO[c]);
            rtab(OFS_CAL + 8'(4 * c), TAB_CAL[c]);
        end
        // Unmapped place answers with an error
        apb(1'b0, 8'hFC, 32'h0);
        bchk(err_q, 1'b1);
        check(rd_q, 32'h0);
        apb(1'b1, 8'hFC, 32'hFFFF);
        bchk(err_q, 1'b1);
        $display("test tables done");
        end_of_test();
    end
endmodule // test_transceiver_low_speed_control
`default_nettype wire
